// file: common/rbd_pkg.sv
// Package for the block B decode and miscellaneous register slice.
// Assumes one 200 MHz clock and a 32-bit host data path.
package rbd_pkg;

  // ==========================================================================
  // Register addresses
  localparam logic [31:0] ADDR_TESTER_CTRL = 32'hFEF80060;
  localparam logic [31:0] ADDR_BLOCK_B_CFG = 32'hFEF80058;
  localparam logic [31:0] ADDR_USEC_CTR    = 32'hFEF80100;
  localparam logic [31:0] ADDR_STRAP_LOW   = 32'hFEF80400;
  localparam logic [31:0] ADDR_STRAP_HIGH  = 32'hFEF80408;
  localparam logic [31:0] ADDR_STORE_LO    = 32'hFEF80800;
  localparam logic [31:0] ADDR_STORE_HI    = 32'hFEF80BF8;
  localparam logic [31:0] ADDR_EXT_LO      = 32'hFEF88000;
  localparam logic [31:0] ADDR_EXT_HI      = 32'hFEF8FFF8;
  localparam logic [11:0] VEC_REGION       = 12'hFFF;

  // ==========================================================================
  // Block B configuration fields
  localparam int          CFG_BASE_LSB  = 20;
  localparam int          CFG_SIZE_LSB  = 16;
  localparam int          CFG_WIDE_BIT  = 12;
  localparam int          CFG_VEC_BIT   = 3;
  localparam int          CFG_EN_BIT    = 1;
  localparam int          CFG_WE_BIT    = 0;
  localparam logic [11:0] CFG_BASE_RST  = 12'hFF4;
  localparam logic [2:0]  CFG_SIZE_RST  = 3'h0;
  localparam logic [2:0]  SIZE_RESERVED = 3'h7;

  // ==========================================================================
  // Transfer sizes in bytes, and store geometry
  localparam logic [5:0]  XFER_BYTE  = 6'h01;
  localparam logic [5:0]  XFER_WORD  = 6'h04;
  localparam logic [5:0]  XFER_BURST = 6'h20;
  localparam int          STORE_DEPTH = 64;
  localparam int          STORE_WIDTH = 16;

  // ==========================================================================
  // Timing
  localparam int          CLK_PERIOD_PS  = 5000;
  localparam int          EXT_ACCESS_NS  = 60;
  localparam int          FLASH_ACCESS_NS = 100;
  localparam logic [5:0]  EXT_CYCLES   =
    6'((EXT_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [5:0]  FLASH_CYCLES =
    6'((FLASH_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [1:0]  STRAP_SETTLE = 2'h3;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [5:0]  size;
    logic [31:0] wdata;
  } rbd_req_s;

  typedef enum logic [1:0] {ST_IDLE, ST_EXT, ST_FLASH, ST_ACK} rbd_state_e;

endpackage

// file: rtl/rbd_regs.sv
// Block B decode, microsecond counter, tester program store, strap capture
// and the off-chip register window of one controller half.
// Assumes the host holds a request until hb_ack and sends no second one
// before that; the memory data pins are shared with the strap capture.
//
// Operation
// - Wide-device bit loads inverse of its strap at power-up; writes ignored.
// - Wide bit zero means byte-wide halves; one means 32-bit or 64-bit parts.
// - Size codes 000..110 decode to 1..64 megabytes; code 111 reserved.
// - Vector bits of both blocks choose who answers the top megabyte.
// - Neither set: none; B set: B; only A set: A; both: B.
// - Block B vector bit loads inverse of its strap at power-up reset.
// - Base compares address bits 20-31, low bits ignored per size.
// - Block B answers its base range only while enable is one.
// - Flash writes happen only while write-enable is one.
// - Legal writes with write-enable low end normally; bad sizes get no answer.
// - Readable, writable 32-bit counter advancing once per microsecond.
// - Microsecond counter clears on power-up and local reset.
// - Tester store holds 64 words of 16 bits; tester only fetches.
// - Low memory data lines latched at power-up into read-only register.
// - High memory data lines latched at power-up into second read-only register.
// - External window maps to static-RAM style cycles on high data lines.
// - External reads of any size but burst; narrow lanes undefined.
// - No duplication across halves; each half serves its own window half.
// - No parity generated on host address or data.
// - Control updates during refresh are tolerated.
`timescale 1ns/1ps

module rbd_regs
  import rbd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        local_rst,
  input  wire rbd_req_s    hb_req,
  output logic             hb_ack,
  output logic [31:0]      hb_rdata,
  input  wire logic        half_is_upper,
  input  wire logic        block_a_vector_source,
  input  wire logic [7:0]  clk_mhz,
  input  wire logic        check_line_three_strap,
  input  wire logic        check_line_one_strap,
  input  wire logic [31:0] memory_data_low_lines,
  input  wire logic [31:0] memory_data_high_lines_i,
  output logic [31:0]      memory_data_high_lines_o,
  output logic             memory_data_high_lines_oe,
  output logic             ext_sel,
  output logic             ext_wr,
  output logic [14:0]      ext_addr,
  output logic [3:0]       ext_lanes,
  output logic             flash_b_sel,
  output logic             flash_b_wr,
  output logic [25:0]      flash_b_addr,
  output logic             flash_b_wide,
  input  wire logic [31:0] flash_b_rdata,
  input  wire logic [5:0]  tester_fetch_addr,
  output logic [15:0]      tester_instr,
  output logic [31:0]      tester_ctrl
);

  // ==========================================================================
  // Strap capture
  // The memory data pins carry the straps only around power-up, so they are
  // caught once after the reset release and then kept.
  logic [65:0] strap_s1;
  logic [65:0] strap_s2;
  logic [65:0] strap_s3;
  logic [1:0]  settle_cnt;
  logic        captured;
  logic [31:0] strap_low;
  logic [31:0] strap_high;
  wire         capture_now = !captured && settle_cnt == STRAP_SETTLE
                             && strap_s2 == strap_s3;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_s1 <= '0;
      strap_s2 <= '0;
      strap_s3 <= '0;
    end
    else
    begin
      strap_s1 <= {check_line_three_strap, check_line_one_strap,
                   memory_data_high_lines_i, memory_data_low_lines};
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      settle_cnt <= '0;
      captured   <= 1'b0;
      strap_low  <= '0;
      strap_high <= '0;
    end
    else
    begin
      if (settle_cnt != STRAP_SETTLE)
        settle_cnt <= settle_cnt + 2'h1;
      if (capture_now)
      begin
        captured   <= 1'b1;
        strap_low  <= strap_s3[31:0];
        strap_high <= strap_s3[63:32];
      end
    end
  end

  // ==========================================================================
  // Host request decode
  // No parity is produced for host address or data.
  rbd_state_e state;
  logic [5:0] wait_cnt;

  wire [31:0] a       = hb_req.addr;
  wire        idle_rq = hb_req.valid && state == ST_IDLE;
  wire        hit_cfg = a == ADDR_BLOCK_B_CFG;
  wire        hit_tst = a == ADDR_TESTER_CTRL;
  wire        hit_ctr = a == ADDR_USEC_CTR;
  wire        hit_sl  = a == ADDR_STRAP_LOW;
  wire        hit_sh  = a == ADDR_STRAP_HIGH;
  wire        hit_st  = a >= ADDR_STORE_LO && a <= (ADDR_STORE_HI | 32'h7);
  wire        hit_ext = a >= ADDR_EXT_LO && a <= (ADDR_EXT_HI | 32'h7)
                        && a[2] == !half_is_upper;

  logic [11:0] base;
  logic [2:0]  size;
  logic        wide;
  logic        vec_b;
  logic        en_b;
  logic        we_b;

  // Ignored low base bits follow the size, so the block aligns to its size.
  wire [11:0] size_mask = 12'hFFF << size;
  wire        hit_base  = en_b && size != SIZE_RESERVED
                          && ((a[31:20] ^ base) & size_mask) == 12'h000;
  wire        in_vec    = a[31:20] == VEC_REGION;
  wire        vec_to_b  = vec_b;
  wire        hit_vec   = in_vec && vec_to_b;
  wire        hit_flash = (hit_base || hit_vec)
                          && !(hit_cfg || hit_tst || hit_ctr || hit_sl
                               || hit_sh || hit_st || hit_ext);

  // Write sizes that the flash path accepts depend on the device width.
  wire        wr_byte   = hb_req.size == XFER_BYTE && !wide;
  wire        wr_word   = hb_req.size == XFER_WORD && wide
                          && a[1:0] == 2'h0;
  wire        flash_ok  = !hb_req.write || wr_byte || wr_word;
  wire        ext_ok    = hb_req.write
                          ? (hb_req.size == XFER_BYTE
                             || hb_req.size == XFER_WORD)
                          : hb_req.size != XFER_BURST;
  wire        reg_hit   = hit_cfg || hit_tst || hit_ctr || hit_sl || hit_sh
                          || hit_st;
  wire        reg_wr    = idle_rq && hb_req.write && reg_hit;

  // ==========================================================================
  // Block B configuration
  wire [31:0] cfg_word = {base, 1'b0, size, 3'h0, wide, 8'h00, vec_b, 1'b0,
                          en_b, we_b};

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      base  <= CFG_BASE_RST;
      size  <= CFG_SIZE_RST;
      en_b  <= 1'b0;
      we_b  <= 1'b0;
      wide  <= 1'b0;
      vec_b <= 1'b0;
    end
    else if (local_rst)
    begin
      base <= CFG_BASE_RST;
      size <= CFG_SIZE_RST;
      en_b <= 1'b0;
      we_b <= 1'b0;
    end
    else
    begin
      // Updates land in one cycle and never touch refresh state.
      if (reg_wr && hit_cfg)
      begin
        base  <= hb_req.wdata[CFG_BASE_LSB +: 12];
        size  <= hb_req.wdata[CFG_SIZE_LSB +: 3];
        vec_b <= hb_req.wdata[CFG_VEC_BIT];
        en_b  <= hb_req.wdata[CFG_EN_BIT];
        we_b  <= hb_req.wdata[CFG_WE_BIT];
      end
      if (capture_now)
      begin
        wide  <= !strap_s3[65];
        vec_b <= !strap_s3[64];
      end
    end
  end

  // Block A takes the vector region only when block B does not claim it.
  logic vec_a_unused;
  assign vec_a_unused = block_a_vector_source && !vec_b;

  // ==========================================================================
  // Microsecond counter
  logic [7:0]  prescale;
  logic [31:0] usec_ctr;
  wire  [7:0]  div_top = (clk_mhz == 8'h00) ? 8'h00 : clk_mhz - 8'h01;
  wire         usec_tick = prescale >= div_top;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prescale <= '0;
      usec_ctr <= '0;
    end
    else if (local_rst)
    begin
      prescale <= '0;
      usec_ctr <= '0;
    end
    else
    begin
      prescale <= usec_tick ? 8'h00 : prescale + 8'h01;
      if (reg_wr && hit_ctr)
        usec_ctr <= hb_req.wdata;
      else if (usec_tick)
        usec_ctr <= usec_ctr + 32'h1;
    end
  end

  // ==========================================================================
  // Tester program store and control
  // The tester side has a read port only, so it can never alter its code.
  logic [STORE_WIDTH-1:0] store [STORE_DEPTH];
  wire  [5:0]             st_idx = a[8:3];

  always_ff @(posedge ref_clk)
  begin
    if (reg_wr && hit_st)
      store[st_idx] <= hb_req.wdata[STORE_WIDTH-1:0];
    tester_instr <= store[tester_fetch_addr];
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      tester_ctrl <= '0;
    else if (reg_wr && hit_tst)
      tester_ctrl <= hb_req.wdata;
  end

  // ==========================================================================
  // Read data mux
  wire [31:0] reg_rdata =
    hit_cfg ? cfg_word :
    hit_tst ? tester_ctrl :
    hit_ctr ? usec_ctr :
    hit_sl  ? strap_low :
    hit_sh  ? strap_high :
    hit_st  ? {16'h0000, store[st_idx]} :
              32'h0000_0000;

  // ==========================================================================
  // Access sequencer
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state                     <= ST_IDLE;
      wait_cnt                  <= '0;
      hb_ack                    <= 1'b0;
      hb_rdata                  <= '0;
      ext_sel                   <= 1'b0;
      ext_wr                    <= 1'b0;
      ext_addr                  <= '0;
      ext_lanes                 <= '0;
      memory_data_high_lines_o  <= '0;
      memory_data_high_lines_oe <= 1'b0;
      flash_b_sel               <= 1'b0;
      flash_b_wr                <= 1'b0;
      flash_b_addr              <= '0;
      flash_b_wide              <= 1'b0;
    end
    else
    begin
      hb_ack       <= 1'b0;
      flash_b_wide <= wide;
      case (state)
        ST_IDLE:
        begin
          if (idle_rq && reg_hit)
          begin
            hb_rdata <= reg_rdata;
            hb_ack   <= 1'b1;
          end
          else if (idle_rq && hit_ext && ext_ok)
          begin
            state     <= ST_EXT;
            wait_cnt  <= EXT_CYCLES;
            ext_sel   <= 1'b1;
            ext_wr    <= hb_req.write;
            ext_addr  <= a[14:0];
            ext_lanes <= (hb_req.size == XFER_BYTE)
                         ? (4'h8 >> a[1:0]) : 4'hF;
            memory_data_high_lines_o  <= hb_req.wdata;
            memory_data_high_lines_oe <= hb_req.write;
          end
          else if (idle_rq && hit_flash && flash_ok)
          begin
            state        <= ST_FLASH;
            wait_cnt     <= FLASH_CYCLES;
            flash_b_sel  <= 1'b1;
            flash_b_wr   <= hb_req.write && we_b;
            flash_b_addr <= a[25:0];
          end
        end
        ST_EXT:
        begin
          wait_cnt <= wait_cnt - 6'h01;
          if (wait_cnt == 6'h01)
          begin
            // Lanes a narrow device leaves open come back as found.
            hb_rdata                  <= memory_data_high_lines_i;
            ext_sel                   <= 1'b0;
            ext_wr                    <= 1'b0;
            memory_data_high_lines_oe <= 1'b0;
            hb_ack                    <= 1'b1;
            state                     <= ST_ACK;
          end
        end
        ST_FLASH:
        begin
          wait_cnt <= wait_cnt - 6'h01;
          if (wait_cnt == 6'h01)
          begin
            hb_rdata    <= flash_b_rdata;
            flash_b_sel <= 1'b0;
            flash_b_wr  <= 1'b0;
            hb_ack      <= 1'b1;
            state       <= ST_ACK;
          end
        end
        ST_ACK:
          state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule

// file: bench/rbd_regs_asserts.sv
// Checker for the block B register slice, watching top-level ports only.
// Assumes the host keeps one request outstanding, as the bench does.
`timescale 1ns/1ps
module rbd_regs_asserts
  import rbd_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire rbd_req_s   hb_req,
  input wire logic       hb_ack,
  input wire logic       half_is_upper,
  input wire logic       ext_sel,
  input wire logic       ext_wr,
  input wire logic [3:0] ext_lanes,
  input wire logic       memory_data_high_lines_oe,
  input wire logic       flash_b_sel,
  input wire logic       flash_b_wr,
  input wire logic       flash_b_wide
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // Helper: the strap capture is over once this saturates.
  logic [3:0] up_cnt;
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b) up_cnt <= '0;
    else if (up_cnt != 4'hF) up_cnt <= up_cnt + 4'h1;
  // ==========================================================================
  // Properties
  a_ack_one_pulse: assert property (hb_ack |=> !hb_ack)
    else $error("ack longer than one cycle");
  a_oe_only_write: assert property (
    memory_data_high_lines_oe |-> ext_sel && ext_wr)
    else $error("data lines driven outside a window write");
  a_ext_timing: assert property (
    $rose(ext_sel) |-> ##12 (hb_ack && !ext_sel))
    else $error("window access not closed on time");
  a_ext_half: assert property (
    $rose(ext_sel) |-> $past(hb_req.addr[2]) != half_is_upper)
    else $error("window access taken for the other half");
  a_ext_word_lanes: assert property (
    $rose(ext_sel) && $past(hb_req.size) == XFER_WORD |-> ext_lanes == 4'hF)
    else $error("word access without all lanes");
  a_flash_timing: assert property (
    $rose(flash_b_sel) |-> ##20 (hb_ack && !flash_b_sel))
    else $error("flash access not closed on time");
  a_flash_wr_sel: assert property (flash_b_wr |-> flash_b_sel)
    else $error("flash write strobe without select");
  a_flash_byte_wide: assert property (
    $rose(flash_b_sel) && $past(hb_req.write)
      && $past(hb_req.size) == XFER_BYTE |-> !flash_b_wide)
    else $error("byte flash write taken on a wide block");
  a_wide_fixed: assert property (
    up_cnt == 4'hF |=> $stable(flash_b_wide))
    else $error("wide bit changed after capture");
  a_reg_latency: assert property (
    $rose(hb_req.valid) && hb_req.addr == ADDR_USEC_CTR |=> hb_ack)
    else $error("counter access not answered next cycle");
  c_ext: cover property ($rose(ext_sel));
  c_flash_wr: cover property ($rose(flash_b_wr));
  c_flash_end: cover property ($fell(flash_b_sel) && hb_ack);
endmodule
bind rbd_regs rbd_regs_asserts u_chk (.ref_clk, .rst_b, .hb_req, .hb_ack,
  .half_is_upper, .ext_sel, .ext_wr, .ext_lanes, .memory_data_high_lines_oe,
  .flash_b_sel, .flash_b_wr, .flash_b_wide);

// file: bench/rbd_far_dev.sv
// Model of the off-chip side: window registers, flash B and strap levels.
// Assumes the bench resolves the shared high data lines from the enable.
`timescale 1ns/1ps
module rbd_far_dev
  import rbd_pkg::*;
#(
  parameter logic [31:0] STRAP_HI = 32'hC3A51E78
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        ext_sel,
  input  wire logic        ext_wr,
  input  wire logic [14:0] ext_addr,
  input  wire logic [31:0] wr_data,
  output logic      [31:0] rd_data,
  input  wire logic        flash_b_sel,
  input  wire logic [25:0] flash_b_addr,
  output logic      [31:0] flash_b_rdata
);
  logic [31:0] mem [16];
  logic [31:0] last;
  logic [3:0]  boot;
  logic [3:0]  idx;
  assign idx = ext_addr[3:0] ^ ext_addr[7:4];
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b) boot <= '0;
    else if (boot != 4'hF) boot <= boot + 4'h1;
  always @(posedge ref_clk)
  begin
    if (ext_sel && ext_wr) mem[idx] <= wr_data;
    last <= ~rd_data;
  end
  // Released lines flip every cycle so a stale sample never matches.
  assign rd_data = (boot < 4'h8) ? STRAP_HI :
                   (ext_sel && !ext_wr) ? mem[idx] : last;
  assign flash_b_rdata = flash_b_sel ? {6'h2A, flash_b_addr} : ~last;
endmodule

// file: bench/test_rom_b_decode_and_misc_regs.sv
// Self-checking bench for the block B register slice.
// Assumes the far side model and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) \
  begin num_checks++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_rom_b_decode_and_misc_regs
  import rbd_pkg::*;
;
  logic ref_clk = 0, rst_b = 0, local_rst = 0, blk_a = 0;
  logic got, fw;
  rbd_req_s req = '0;
  logic [5:0] fetch = '0;
  logic [31:0] rd, v, seed = 32'h7478AC72;
  logic [31:0] store [64];
  logic [31:0] ext [4];
  int errors = 0, num_checks = 0, cyc = 0, c1, i;
  wire hb_ack, hi_oe, ext_sel, ext_wr, f_sel, f_wr, f_wide;
  wire [31:0] hb_rdata, hi_o, hi_i, far_rd, f_rd, tctrl;
  wire [14:0] ext_addr;
  wire [3:0] lanes;
  wire [25:0] f_addr;
  wire [15:0] instr;
  assign hi_i = hi_oe ? hi_o : far_rd;
  rbd_regs dut (.ref_clk, .rst_b, .local_rst, .hb_req(req), .hb_ack,
    .hb_rdata, .half_is_upper(1'b1), .block_a_vector_source(blk_a),
    .clk_mhz(8'h04), .check_line_three_strap(1'b0),
    .check_line_one_strap(1'b0), .memory_data_low_lines(32'h5A0F96E1),
    .memory_data_high_lines_i(hi_i), .memory_data_high_lines_o(hi_o),
    .memory_data_high_lines_oe(hi_oe), .ext_sel, .ext_wr, .ext_addr,
    .ext_lanes(lanes), .flash_b_sel(f_sel), .flash_b_wr(f_wr),
    .flash_b_addr(f_addr), .flash_b_wide(f_wide), .flash_b_rdata(f_rd),
    .tester_fetch_addr(fetch), .tester_instr(instr), .tester_ctrl(tctrl));
  rbd_far_dev far (.ref_clk, .rst_b, .ext_sel, .ext_wr, .ext_addr,
    .wr_data(hi_o), .rd_data(far_rd), .flash_b_sel(f_sel),
    .flash_b_addr(f_addr), .flash_b_rdata(f_rd));
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (f_wr === 1'b1) fw = 1'b1;
    if (cyc == 20000)
    begin
      errors++;
      conclude();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic conclude();
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // A refused request is held for 40 cycles, then withdrawn.
  task automatic acc(input logic w, input logic [31:0] a, d,
                     input logic [5:0] sz, input logic ok);
    int n;
    got = 1'b0;
    @(negedge ref_clk);
    req = '{1'b1, w, a, sz, d};
    for (n = 0; n < 40 && !got; n++)
    begin
      @(posedge ref_clk);
      #1;
      got = hb_ack;
      rd = hb_rdata;
    end
    @(negedge ref_clk);
    req.valid = 1'b0;
    `CHK(got, ok)
  endtask
  task automatic rchk(input logic [31:0] a, e);
    acc(1'b0, a, '0, XFER_WORD, 1'b1);
    `CHK(rd, e)
  endtask
  // Flash settings change only while block B is idle, and no memory
  // access stands next to the update.
  task automatic cfg(input logic [31:0] d);
    acc(1'b1, ADDR_BLOCK_B_CFG, d, XFER_WORD, 1'b1);
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk) rst_b = 1'b1;
    repeat (8) @(posedge ref_clk);
    rchk(ADDR_BLOCK_B_CFG, 32'hFF401008);
    `CHK(f_wide, 1'b1)
    rchk(ADDR_STRAP_LOW, 32'h5A0F96E1);
    rchk(ADDR_STRAP_HIGH, 32'hC3A51E78);
    for (i = 0; i < 6; i++)
    begin
      v = rnd() & 32'hFFFFFFFD;
      cfg(v);
      rchk(ADDR_BLOCK_B_CFG, (v & 32'hFFF7000B) | 32'h1000);
    end
    for (i = 0; i < 64; i++)
    begin
      store[i] = rnd();
      acc(1'b1, ADDR_STORE_LO + 32'(i * 8), store[i], XFER_WORD, 1'b1);
    end
    for (i = 0; i < 64; i++)
    begin
      rchk(ADDR_STORE_LO + 32'(i * 8), {16'h0, store[i][15:0]});
      fetch = 6'(i);
      @(posedge ref_clk);
      #1;
      `CHK(instr, store[i][15:0])
    end
    acc(1'b1, ADDR_TESTER_CTRL, 32'h5AFC, XFER_WORD, 1'b1);
    rchk(ADDR_TESTER_CTRL, 32'h5AFC);
    `CHK(tctrl, 32'h5AFC)
    cfg(32'h0FF7000B);
    @(negedge ref_clk) local_rst = 1'b1;
    @(negedge ref_clk) local_rst = 1'b0;
    acc(1'b0, ADDR_USEC_CTR, '0, XFER_WORD, 1'b1);
    `CHK(rd < 32'h2, 1'b1)
    rchk(ADDR_BLOCK_B_CFG, 32'hFF401008);
    acc(1'b1, ADDR_USEC_CTR, 32'hFFFFFFF0, XFER_WORD, 1'b1);
    c1 = cyc;
    repeat (40) @(posedge ref_clk);
    acc(1'b0, ADDR_USEC_CTR, '0, XFER_WORD, 1'b1);
    v = rd - 32'hFFFFFFF0;
    c1 = (cyc - c1) / 4;
    `CHK(v + 1 >= c1 && v <= c1 + 1, 1'b1)
    for (i = 0; i < 4; i++)
    begin
      ext[i] = rnd();
      acc(1'b1, ADDR_EXT_LO + 32'(i * 16), ext[i], XFER_WORD, 1'b1);
    end
    for (i = 0; i < 4; i++)
      rchk(ADDR_EXT_LO + 32'(i * 16), ext[i]);
    acc(1'b0, ADDR_EXT_LO, '0, XFER_BYTE, 1'b1);
    acc(1'b0, ADDR_EXT_LO + 32'h4, '0, XFER_WORD, 1'b0);
    acc(1'b0, ADDR_EXT_LO, '0, XFER_BURST, 1'b0);
    acc(1'b1, ADDR_EXT_LO, '0, 6'h02, 1'b0);
    acc(1'b1, ADDR_EXT_LO, rnd(), XFER_BYTE, 1'b1);
    fw = 1'b0;
    cfg(32'h1000000A);
    rchk(32'h10000010, 32'hA8000010);
    acc(1'b1, 32'h10000010, rnd(), XFER_WORD, 1'b1);
    `CHK(fw, 1'b0)
    acc(1'b1, 32'h10000010, rnd(), XFER_BYTE, 1'b0);
    acc(1'b1, 32'h10000012, rnd(), XFER_WORD, 1'b0);
    cfg(32'h1000000B);
    acc(1'b1, 32'h10000010, rnd(), XFER_WORD, 1'b1);
    `CHK(fw, 1'b1)
    // Size walk: each size is probed just inside and just past its end.
    for (i = 0; i < 8; i++)
    begin
      cfg(32'h1000000A | (i << 16));
      v = 32'h10000000 + (32'h100000 << i);
      acc(1'b0, v - 32'h8, '0, XFER_WORD, i < 7);
      acc(1'b0, v, '0, XFER_WORD, 1'b0);
    end
    cfg(32'h1011000A);
    acc(1'b0, 32'h10000000, '0, XFER_WORD, 1'b1);
    acc(1'b0, 32'h10200000, '0, XFER_WORD, 1'b0);
    cfg(32'h10000008);
    acc(1'b0, 32'h10000000, '0, XFER_WORD, 1'b0);
    acc(1'b0, 32'hFFF00040, '0, XFER_WORD, 1'b1);
    blk_a = 1'b1;
    acc(1'b0, 32'hFFF00040, '0, XFER_WORD, 1'b1);
    cfg(32'h10000000);
    acc(1'b0, 32'hFFF00040, '0, XFER_WORD, 1'b0);
    blk_a = 1'b0;
    acc(1'b0, 32'hFFF00040, '0, XFER_WORD, 1'b0);
    conclude();
  end
endmodule
